// File: dv/scd_host.sv
// Purpose: Host model shifting frames into the decoder
// Assumes: Mode 1, MSB first, sck idle low
// Notes:   Link clock gated, so sck stands still between frames
module scd_host (
  output logic        sck,
  output logic        cs_n,
  output logic        mosi,
  input  wire logic   miso,
  output logic [15:0] rx_word,
  output logic        rx_stb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lclk;
  logic en;

  initial
  begin
    {en, mosi, rx_stb, rx_word} = '0;
    cs_n = 1'b1;
    lclk = 1'b0;
    #7;
    forever #24 lclk = ~lclk;
  end
  assign sck = lclk & en;

  task automatic frame(input logic [15:0] w, input int n);
    logic [15:0] rx;
    logic [15:0] sh;
    rx = '0;
    sh = w;
    @(negedge lclk) cs_n <= 1'b0;
    // Long lead so miso is enabled before the first rise; the answer's first bit follows on that rise
    repeat (10) @(negedge lclk);
    en <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(posedge lclk) mosi <= sh[15];
      sh = sh << 1;
      @(negedge lclk) rx = {rx[14:0], miso};
    end
    en <= 1'b0;
    @(negedge lclk) cs_n <= 1'b1;
    mosi <= ~mosi;
    rx_word <= rx;
    rx_stb <= 1'b1;
    @(negedge lclk) rx_stb <= 1'b0;
    repeat (11) @(negedge lclk);
  endtask
endmodule // scd_host

// File: dv/scd_sva.sv
// Purpose: Port-level assertions for the config decoder
// Assumes: Link signals are seen only as sampled by clk
// Notes:   Bound to every decoder instance
module scd_sva (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       spi_cs_n,
  input wire logic       spi_miso_oe_n,
  input wire logic [3:0] fire_enable_input,
  input wire logic [3:0] fire_enable,
  input wire logic [1:0] firing_profile_field,
  input wire logic [1:0] latch_time_field,
  input wire logic       soft_reset_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  oe_release_a: assert property (spi_cs_n [*4] |-> spi_miso_oe_n)
    else $error("miso driven outside a frame");
  oe_drive_a: assert property (!spi_cs_n [*4] |-> !spi_miso_oe_n)
    else $error("miso not driven inside a frame");
  pulse_single_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
  pulse_clear_a: assert property (soft_reset_pulse |-> firing_profile_field == 2'h0 && latch_time_field == 2'h0)
    else $error("settings survive soft reset");
  field_gap_a: assert property (!$stable({firing_profile_field, latch_time_field}) |-> $past(spi_cs_n, 2))
    else $error("setting changed inside a frame");
  pulse_gap_a: assert property (soft_reset_pulse |-> $past(spi_cs_n, 2) && spi_cs_n)
    else $error("soft reset inside a frame");
  fen_start_a: assert property ($rose(fire_enable_input[0]) |-> ##[1:4] fire_enable[0])
    else $error("fire enable late");
  fen_hold_a: assert property (fire_enable_input[3] [*4] |-> fire_enable[3])
    else $error("fire enable dropped while input high");
  fen_zero_a: assert property ((!fire_enable_input[1] && latch_time_field == 2'h0) [*8] |-> !fire_enable[1])
    else $error("fire enable stretched with zero latch");
endmodule // scd_sva

bind scd_config_decoder scd_sva sva_u (
  .clk                  (clk),
  .arst_n               (arst_n),
  .spi_cs_n             (spi_cs_n),
  .spi_miso_oe_n        (spi_miso_oe_n),
  .fire_enable_input    (fire_enable_input),
  .fire_enable          (fire_enable),
  .firing_profile_field (firing_profile_field),
  .latch_time_field     (latch_time_field),
  .soft_reset_pulse     (soft_reset_pulse)
);

// File: dv/tb.sv
// Purpose: Self-checking bench for the config decoder
// Assumes: Latch unit shortened to 20 clocks
// Notes:   Answers checked from a queue of notes, one per frame
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int UNIT = 20;
  logic        clk, arst_n, spi_sck, spi_cs_n, spi_mosi, spi_miso_o, spi_miso_oe_n;
  logic        soft_reset_pulse, rx_stb, armed;
  logic [3:0]  fire_enable_input, fire_enable;
  logic [1:0]  firing_profile_field, latch_time_field, prof, lat;
  logic [15:0] rx_word, pend;
  logic [15:0] expq[$];
  logic [31:0] seed;
  int          errors, checks, cyc, pulses;
  // Released miso idles high
  wire miso_line = spi_miso_oe_n ? 1'b1 : spi_miso_o;

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  scd_config_decoder #(.LATCH_UNIT_CYCLES(UNIT)) dut_u (
    .clk(clk), .arst_n(arst_n), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe_n(spi_miso_oe_n),
    .fire_enable_input(fire_enable_input), .fire_enable(fire_enable),
    .firing_profile_field(firing_profile_field), .latch_time_field(latch_time_field),
    .soft_reset_pulse(soft_reset_pulse));
  scd_host host_u (.sck(spi_sck), .cs_n(spi_cs_n), .mosi(spi_mosi), .miso(miso_line),
    .rx_word(rx_word), .rx_stb(rx_stb));

  function automatic logic [15:0] par(logic [15:0] w);
    w[13] = 1'b0;
    return {w[15:14], ~^w, w[12:0]};
  endfunction

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic xfer(logic [15:0] c, int n);
    logic nxt;
    expq.push_back(n == 15 ? pend >> 1 : (n == 17 ? pend << 1 : pend));
    host_u.frame(c, n);
    nxt = 1'b0;
    if (n != 16)
      pend = 16'hd003;
    else if (~^c)
      pend = 16'hd000;
    else if (c[15:14] != 2'h0 || c[11:10] == 2'h3)
      pend = par({c[15:8], 8'h00});
    else if (c[10])
    begin
      if (c[12])
        lat = c[9:8];
      pend = par({3'h0, c[12], 2'h1, lat, 8'h00});
    end
    else if (c[12] && c[11] && c[7:0] == 8'h55 && armed)
    begin
      prof = 2'h0;
      lat = 2'h0;
      pend = 16'h2003;
    end
    else
    begin
      if (c[12] && !c[11])
        prof = c[9:8];
      nxt = c[12] && c[11] && c[7:0] == 8'haa;
      pend = par({3'h0, c[12], c[11], 1'b0, prof, 8'h02});
    end
    armed = nxt;
    chk("profile", {14'h0, prof}, {14'h0, firing_profile_field});
    chk("latch", {14'h0, lat}, {14'h0, latch_time_field});
  endtask

  task automatic pulse_fen(int ch);
    @(posedge clk) fire_enable_input[ch] <= 1'b1;
    repeat (4) @(posedge clk);
    fire_enable_input[ch] <= 1'b0;
  endtask

  task automatic timer_run(int ch);
    int hi;
    int dur;
    xfer(par({3'h0, 3'h5, ch[1:0], 8'h00}), 16);
    dur = ch == 3 ? 4 * UNIT : ch * UNIT;
    if (dur < 4)
      dur = 4;
    hi = 0;
    fork
      pulse_fen(ch);
      repeat (130) @(posedge clk) hi += int'(fire_enable[ch]);
    join
    checks++;
    if (hi < dur - 1 || hi > dur + 1)
    begin
      errors++;
      $display("Error stretch expected %0d seen %0d", dur, hi);
    end
  endtask

  always @(posedge rx_stb) chk("answer", expq.pop_front(), rx_word);

  // Completed soft resets, each must show as one pulse
  always @(posedge clk)
  begin
    if (soft_reset_pulse === 1'b1)
      pulses++;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      wrap_up();
    end
  end

  initial
  begin
    arst_n = 1'b0;
    fire_enable_input = 4'h0;
    seed = 32'ha6dc51a1;
    {pend, prof, lat, armed} = '0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int p = 0; p < 4; p++)
      xfer(par({6'h04, p[1:0], 8'h5a}), 16);
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      xfer(par({3'h0, seed[12], 2'h0, seed[9:0]}), 16);
    end
    xfer(par(16'h08aa), 16);
    xfer(par(16'h1855), 16);
    $display("Test profiles done");
    xfer(par(16'h1a03), 16);
    xfer(par(16'h18aa), 16);
    xfer(par(16'h0800), 16);
    xfer(par(16'h1855), 16);
    xfer(par(16'h18aa), 16);
    xfer(par(16'h1855) ^ 16'h2000, 16);
    xfer(par(16'h1855), 16);
    xfer(par(16'h18aa), 16);
    xfer(par(16'h18aa), 15);
    xfer(par(16'h1855), 16);
    xfer(par(16'h1b00), 17);
    xfer(par(16'h4900), 16);
    xfer(par(16'h18aa), 16);
    xfer(par(16'h1855), 16);
    $display("Test sequence done");
    xfer(par(16'h0700), 16);
    for (int ch = 0; ch < 4; ch++)
      timer_run(ch);
    $display("Test timers done");
    xfer(par(16'h1700), 16);
    pulse_fen(2);
    xfer(par(16'h18aa), 16);
    xfer(par(16'h1855), 16);
    repeat (8) @(posedge clk);
    chk("timers", 16'h0, {12'h0, fire_enable});
    xfer(par(16'h0000), 16);
    chk("resets", 16'h0002, 16'(pulses));
    $display("Test soft reset done");
    wrap_up();
  end
endmodule // tb

// File: verilog/scd_config_decoder.sv
// Purpose: Configuration command decoder behind the squib SPI port
// Assumes: Host shifts mode 1 frames, MSB first, sck idle low between frames
// Notes:   Link counter is free running; frame length is the count difference
//
// What this block does
// - Every command and response word except the 0x0000 power-on answer has bit 13 set for odd parity.
// - Config one with read bit clear only drops a pending reset sequence; low bits ignored.
// - Config one write, select clear: store firing profile from bits 9:8.
// - Config one write, select set: bits 7:0 are a soft reset byte.
// - Profile codes: 1.2A/2ms default, 1.5A/2ms, 1.75A/0.65ms, 1.75A/1ms.
// - Normal config one answer echoes command bits, profile, tail 0x02.
// - Soft reset only if 0x55 directly follows 0xAA; else sequence dropped.
// - Soft reset clears profile, latch, sequence and timer counts like power-on, except the answer.
// - Answer bit 0 reports one after a valid reset sequence.
// - Valid soft reset sequence answers 0x2003 in the next frame.
// - Config two write stores fire-enable latch duration from bits 9:8.
// - Latch codes: 0 ms, 128 ms, 256 ms, 512 ms.
// - Four independent stretch timers, each started by its own input.
// - Latch duration returns to 00 after reset.
// - Config two answer echoes command bits, latch field, zero tail.
// - Answers are shifted out during the next frame.
// - After first reset byte answer 0x1X02, or 0x3X02 when parity sets bit 13, with the stored profile.
// - Parity error answers 0xD000, wrong clock count 0xD003.
module scd_config_decoder #(
  parameter int unsigned LATCH_UNIT_CYCLES = scd_pkg::LATCH_UNIT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       spi_sck,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_mosi,
  output logic            spi_miso_o,
  output logic            spi_miso_oe_n,
  input  wire logic [3:0] fire_enable_input,
  output logic      [3:0] fire_enable,
  output logic      [1:0] firing_profile_field,
  output logic      [1:0] latch_time_field,
  output logic            soft_reset_pulse
);

  localparam int unsigned CW = scd_pkg::LINK_CNT_W;
  localparam int unsigned TW = scd_pkg::TIMER_W;

  // Sets bit 13 so the whole word has an odd number of ones
  function automatic logic [15:0] with_parity(input logic [15:0] w);
    logic [15:0] t;
    t = w;
    t[scd_pkg::PARITY_POS] = 1'b0;
    t[scd_pkg::PARITY_POS] = ~(^t);
    return t;
  endfunction

  // Link side: sck domain
  logic [15:0]   rx_reg;
  logic [15:0]   rx_next;
  logic [CW-1:0] bit_cnt_reg;
  logic [CW-1:0] bit_cnt_next;
  logic          miso_reg;
  logic          miso_next;
  logic [CW-1:0] tx_idx;

  // Core side
  logic [15:0]      resp_reg;
  logic [15:0]      resp_next;
  logic [CW-1:0]    base_reg;
  logic [CW-1:0]    base_next;
  logic             cs_q_reg;
  logic             oe_n_reg;
  logic [1:0]       profile_reg;
  logic [1:0]       profile_next;
  logic [1:0]       latch_reg;
  logic [1:0]       latch_next;
  scd_pkg::scd_seq_e seq_reg;
  scd_pkg::scd_seq_e seq_next;
  logic             srst_reg;
  logic             srst_next;
  logic             cs_sync;
  logic [3:0]       fen_sync;
  logic             frame_end;
  logic [CW-1:0]    frame_len;
  logic [15:0]      cmd;
  logic [7:0]       seq_byte;
  logic             is_config;
  logic [TW-1:0]    duration;

  // Receive: host drives on rising, device samples on falling
  always_comb
  begin
    rx_next      = {rx_reg[14:0], spi_mosi};
    bit_cnt_next = bit_cnt_reg + 1'b1;
  end

  always_ff @(negedge spi_sck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_reg      <= '0;
      bit_cnt_reg <= '0;
    end
    else
    begin
      rx_reg      <= rx_next;
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // Transmit: base_reg and resp_reg only change while cs is high,
  // so the sck domain sees them static throughout a frame
  assign tx_idx = bit_cnt_reg - base_reg;

  always_comb
  begin
    if (tx_idx < CW'(scd_pkg::FRAME_BITS))
      miso_next = resp_reg[4'(15) - tx_idx[3:0]];
    else
      miso_next = 1'b0;
  end

  always_ff @(posedge spi_sck or negedge arst_n)
  begin
    if (!arst_n)
      miso_reg <= 1'b0;
    else
      miso_reg <= miso_next;
  end

  assign spi_miso_o = miso_reg;

  // Crossings into the core domain
  // Idle-high reset value: no false frame end right after reset
  scd_sync #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_cs_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in (spi_cs_n),
    .sync_out (cs_sync)
  );

  scd_sync #(
    .W (4)
  ) u_fen_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in (fire_enable_input),
    .sync_out (fen_sync)
  );

  // Frame ends when synchronised cs rises; sck is idle by then,
  // so the link counter and receive word are stable to sample
  assign frame_end = cs_sync & ~cs_q_reg;
  assign frame_len = bit_cnt_reg - base_reg;
  assign cmd       = rx_reg;
  assign seq_byte  = cmd[7:0];
  assign is_config = cmd[scd_pkg::MODE_HI_POS:scd_pkg::MODE_LO_POS] == scd_pkg::MODE_CONFIG;

  always_comb
  begin
    resp_next    = resp_reg;
    base_next    = base_reg;
    profile_next = profile_reg;
    latch_next   = latch_reg;
    seq_next     = seq_reg;
    srst_next    = 1'b0;
    if (frame_end)
    begin
      base_next = bit_cnt_reg;
      // Any frame other than a first byte drops a pending sequence
      seq_next  = scd_pkg::SEQ_IDLE;
      if (frame_len != CW'(scd_pkg::FRAME_BITS))
      begin
        resp_next = scd_pkg::RESP_LENGTH_ERR;
      end
      else if (^cmd == 1'b0)
      begin
        resp_next = scd_pkg::RESP_PARITY_ERR;
      end
      else if (is_config && !cmd[scd_pkg::CMD2_POS])
      begin
        if (!cmd[scd_pkg::RW_POS])
        begin
          // Read: only the answer changes, and a pending sequence is dropped
          resp_next = with_parity({2'h0, 1'b0, 1'b0, cmd[scd_pkg::SELECT_POS], 1'b0,
                                   profile_reg, scd_pkg::TAIL_CFG1});
        end
        else if (!cmd[scd_pkg::SELECT_POS])
        begin
          profile_next = cmd[scd_pkg::FIELD_HI_POS:scd_pkg::FIELD_LO_POS];
          resp_next    = with_parity({2'h0, 1'b0, 1'b1, 1'b0, 1'b0,
                                      cmd[scd_pkg::FIELD_HI_POS:scd_pkg::FIELD_LO_POS],
                                      scd_pkg::TAIL_CFG1});
        end
        else if (seq_byte == scd_pkg::SEQ_FIRST)
        begin
          seq_next  = scd_pkg::SEQ_ARMED;
          resp_next = with_parity({2'h0, 1'b0, 1'b1, 1'b1, 1'b0,
                                   profile_reg, scd_pkg::TAIL_CFG1});
        end
        else if (seq_byte == scd_pkg::SEQ_SECOND && seq_reg == scd_pkg::SEQ_ARMED)
        begin
          // Completed sequence: state back to power-on values
          profile_next = scd_pkg::PROFILE_RESET;
          latch_next   = scd_pkg::LATCH_RESET;
          srst_next    = 1'b1;
          resp_next    = scd_pkg::RESP_RESET_DONE;
        end
        else
        begin
          // Unmatched byte: profile bits ignored, status bit stays 0
          resp_next = with_parity({2'h0, 1'b0, 1'b1, 1'b1, 1'b0,
                                   profile_reg, scd_pkg::TAIL_CFG1});
        end
      end
      else if (is_config && !cmd[scd_pkg::SELECT_POS])
      begin
        if (cmd[scd_pkg::RW_POS])
          latch_next = cmd[scd_pkg::FIELD_HI_POS:scd_pkg::FIELD_LO_POS];
        resp_next = with_parity({2'h0, 1'b0, cmd[scd_pkg::RW_POS], 1'b0, 1'b1,
                                 cmd[scd_pkg::RW_POS] ?
                                   cmd[scd_pkg::FIELD_HI_POS:scd_pkg::FIELD_LO_POS] : latch_reg,
                                 scd_pkg::TAIL_CFG2});
      end
      else
      begin
        // Commands of other blocks, and config two with select set: echo the header only
        resp_next = with_parity({cmd[15:8], 8'h00});
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      resp_reg    <= scd_pkg::RESP_POR;
      base_reg    <= '0;
      cs_q_reg    <= 1'b1;
      oe_n_reg    <= 1'b1;
      profile_reg <= scd_pkg::PROFILE_RESET;
      latch_reg   <= scd_pkg::LATCH_RESET;
      seq_reg     <= scd_pkg::SEQ_IDLE;
      srst_reg    <= 1'b0;
    end
    else
    begin
      resp_reg    <= resp_next;
      base_reg    <= base_next;
      cs_q_reg    <= cs_sync;
      oe_n_reg    <= cs_sync;
      profile_reg <= profile_next;
      latch_reg   <= latch_next;
      seq_reg     <= seq_next;
      srst_reg    <= srst_next;
    end
  end

  assign spi_miso_oe_n        = oe_n_reg;
  assign firing_profile_field = profile_reg;
  assign latch_time_field     = latch_reg;
  assign soft_reset_pulse     = srst_reg;

  // Duration in core cycles; 512 ms still fits the timer width
  always_comb
  begin
    case (latch_reg)
      scd_pkg::LATCH_128MS: duration = TW'(LATCH_UNIT_CYCLES);
      scd_pkg::LATCH_256MS: duration = TW'(2 * LATCH_UNIT_CYCLES);
      scd_pkg::LATCH_512MS: duration = TW'(4 * LATCH_UNIT_CYCLES);
      default:              duration = '0;
    endcase
  end

  for (genvar i = 0; i < scd_pkg::NUM_TIMERS; i++)
  begin : g_timer
    scd_stretch_timer #(
      .CW (TW)
    ) u_timer (
      .clk        (clk),
      .arst_n     (arst_n),
      .clear      (srst_reg),
      .trig_level (fen_sync[i]),
      .duration   (duration),
      .stretched  (fire_enable[i])
    );
  end

endmodule // scd_config_decoder

// File: verilog/scd_pkg.sv
// Purpose: Shared constants for the squib configuration command decoder
// Assumes: 16-bit frames, odd parity carried in bit 13, core clock of 10 MHz
// Notes:   Timing counts derive from the printed times and the core clock rate
package scd_pkg;

  localparam int unsigned FRAME_BITS   = 16;
  localparam int unsigned LINK_CNT_W   = 8;
  localparam int unsigned NUM_TIMERS   = 4;
  localparam int unsigned TIMER_W      = 24;

  // Command field positions
  localparam int unsigned MODE_HI_POS  = 15;
  localparam int unsigned MODE_LO_POS  = 14;
  localparam int unsigned PARITY_POS   = 13;
  localparam int unsigned RW_POS       = 12;
  localparam int unsigned SELECT_POS   = 11;
  localparam int unsigned CMD2_POS     = 10;
  localparam int unsigned FIELD_HI_POS = 9;
  localparam int unsigned FIELD_LO_POS = 8;

  localparam logic [1:0]  MODE_CONFIG  = 2'h0;
  localparam logic [7:0]  SEQ_FIRST    = 8'haa;
  localparam logic [7:0]  SEQ_SECOND   = 8'h55;
  localparam logic [7:0]  TAIL_CFG1    = 8'h02;
  localparam logic [7:0]  TAIL_CFG2    = 8'h00;

  // Fixed answers
  localparam logic [15:0] RESP_POR        = 16'h0000;
  localparam logic [15:0] RESP_PARITY_ERR = 16'hd000;
  localparam logic [15:0] RESP_LENGTH_ERR = 16'hd003;
  localparam logic [15:0] RESP_RESET_DONE = 16'h2003;

  // Firing profile codes, applied to all channels
  localparam logic [1:0]  PROFILE_1A20_2MS  = 2'h0;
  localparam logic [1:0]  PROFILE_1A50_2MS  = 2'h1;
  localparam logic [1:0]  PROFILE_1A75_065MS = 2'h2;
  localparam logic [1:0]  PROFILE_1A75_1MS  = 2'h3;
  localparam logic [1:0]  PROFILE_RESET     = PROFILE_1A20_2MS;

  // Latch duration codes: 0, 1, 2 or 4 units of 128 ms
  localparam logic [1:0]  LATCH_0MS    = 2'h0;
  localparam logic [1:0]  LATCH_128MS  = 2'h1;
  localparam logic [1:0]  LATCH_256MS  = 2'h2;
  localparam logic [1:0]  LATCH_512MS  = 2'h3;
  localparam logic [1:0]  LATCH_RESET  = LATCH_0MS;

  localparam int unsigned CLK_HZ            = 10000000;
  localparam int unsigned LATCH_UNIT_MS     = 128;
  localparam int unsigned LATCH_UNIT_CYCLES = LATCH_UNIT_MS * (CLK_HZ / 1000);

  typedef enum logic [0:0] {SEQ_IDLE, SEQ_ARMED} scd_seq_e;

endpackage : scd_pkg

// File: verilog/scd_stretch_timer.sv
// Purpose: Pulse stretcher for one fire-enable input
// Assumes: Trigger is already synchronised to clk
// Notes:   Duration is sampled at the rising edge of the trigger
module scd_stretch_timer #(
  parameter int unsigned CW = 24
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          clear,
  input  wire logic          trig_level,
  input  wire logic [CW-1:0] duration,
  output logic               stretched
);

  logic          prev_reg;
  logic          prev_next;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic          out_reg;
  logic          out_next;

  always_comb
  begin
    prev_next  = trig_level;
    count_next = count_reg;
    if (clear)
      count_next = '0;
    else if (trig_level && !prev_reg)
      count_next = duration;
    else if (count_reg != '0)
      count_next = count_reg - 1'b1;
    // Output holds while input is high and while time remains
    out_next = trig_level | (count_next != '0);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prev_reg  <= 1'b0;
      count_reg <= '0;
      out_reg   <= 1'b0;
    end
    else
    begin
      prev_reg  <= prev_next;
      count_reg <= count_next;
      out_reg   <= out_next;
    end
  end

  assign stretched = out_reg;

endmodule // scd_stretch_timer

// File: verilog/scd_sync.sv
// Purpose: Two-flop level synchroniser into the core clock domain
// Assumes: Inputs are levels that stay put for several core clocks
// Notes:   First stage feeds only the second stage; reset value set per use
module scd_sync #(
  parameter int unsigned   W       = 1,
  parameter logic [W-1:0]  RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // Reset to the pin's idle level, else release looks like an edge
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule // scd_sync
